// file: core/drive_param_bank.sv
// drive parameter bank: 16-bit settings reached by register number
// assumes the link decoder runs on clk_sys and issues one access at a time
//
// Overview of operation
// - accel arrival threshold as high/low words
// - decel arrival threshold as high/low words
// - second accel/decel threshold pair, same range
// - PID deviation level 0 to 1000
// - PID feedback max and min 0 to 1000
// - four over-torque levels 0 to 150
// - thermal warning level 0 to 100
// - alarm code width: off, 3 or 4 bits
// - zero-speed level 0 to 10000
// - heat-sink warning level 0 to 200
// - line rate: loopback, 2400 to 19200
// - character length seven or eight bits
// - parity none, even or odd
// - one or two stop bits
// - link error action selects five reactions
// - protocol select: ASCII or RTU
`timescale 1ns/100ps
`include "drive_param_params.svh"

module drive_param_bank
  import drive_param_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire param_req_t req,
  output param_rsp_t rsp,
  output logic [`NUM_PARAMS-1:0][15:0] bank,
  output link_cfg_t linkCfg
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // map a register number to its slot; anything else is a miss
  function automatic addr_hit_t decodeAddr(input logic [15:0] addr);
    addr_hit_t r;
    r.hit = 1'b1;
    r.idx = IX_ACCEL_HI;
    if (addr == `ADDR_ACCEL_HI) r.idx = IX_ACCEL_HI;
    else if (addr == `ADDR_ACCEL_LO) r.idx = IX_ACCEL_LO;
    else if (addr == `ADDR_DECEL_HI) r.idx = IX_DECEL_HI;
    else if (addr == `ADDR_DECEL_LO) r.idx = IX_DECEL_LO;
    else if (addr == `ADDR_PID_DEV) r.idx = IX_PID_DEV;
    else if (addr == `ADDR_ACCEL2_HI) r.idx = IX_ACCEL2_HI;
    else if (addr == `ADDR_ACCEL2_LO) r.idx = IX_ACCEL2_LO;
    else if (addr == `ADDR_DECEL2_HI) r.idx = IX_DECEL2_HI;
    else if (addr == `ADDR_DECEL2_LO) r.idx = IX_DECEL2_LO;
    else if (addr == `ADDR_PID_FB_MAX) r.idx = IX_PID_FB_MAX;
    else if (addr == `ADDR_PID_FB_MIN) r.idx = IX_PID_FB_MIN;
    else if (addr == `ADDR_OTQ_FD) r.idx = IX_OTQ_FD;
    else if (addr == `ADDR_OTQ_RR) r.idx = IX_OTQ_RR;
    else if (addr == `ADDR_OTQ_RD) r.idx = IX_OTQ_RD;
    else if (addr == `ADDR_OTQ_FR) r.idx = IX_OTQ_FR;
    else if (addr == `ADDR_THERMAL) r.idx = IX_THERMAL;
    else if (addr == `ADDR_ALARM_W) r.idx = IX_ALARM_W;
    else if (addr == `ADDR_ZERO_SPD) r.idx = IX_ZERO_SPD;
    else if (addr == `ADDR_HEATSINK) r.idx = IX_HEATSINK;
    else if (addr == `ADDR_LINE_RATE) r.idx = IX_LINE_RATE;
    else if (addr == `ADDR_NODE) r.idx = IX_NODE;
    else if (addr == `ADDR_CHAR_LEN) r.idx = IX_CHAR_LEN;
    else if (addr == `ADDR_PARITY) r.idx = IX_PARITY;
    else if (addr == `ADDR_STOP_BITS) r.idx = IX_STOP_BITS;
    else if (addr == `ADDR_ERR_ACTION) r.idx = IX_ERR_ACTION;
    else if (addr == `ADDR_PROTOCOL) r.idx = IX_PROTOCOL;
    else r.hit = 1'b0; // reserved or outside the bank
    return r;
  endfunction : decodeAddr

  // reset value of each slot; link settings start in a usable state
  function automatic logic [15:0] resetValue(input int slot);
    logic [15:0] v;
    v = `RST_ZERO;
    if (slot == int'(IX_LINE_RATE)) v = `RST_LINE_RATE;
    else if (slot == int'(IX_NODE)) v = `RST_NODE;
    else if (slot == int'(IX_CHAR_LEN)) v = `RST_CHAR_LEN;
    else if (slot == int'(IX_STOP_BITS)) v = `RST_STOP_BITS;
    return v;
  endfunction : resetValue

  ////////////////////////////////////////////////////////////////////////
  // access decode

  addr_hit_t dec; // slot addressed by the current request
  logic valueOk; // write data is inside the slot's range
  logic writeOk; // write will be stored this cycle
  logic refused; // access answered with an error

  always_comb
  begin
    dec = decodeAddr(req.addr);
  end

  // limits live in their own module so the table can be reviewed alone
  param_range_check u_range
  (
    .idx(dec.idx),
    .value(req.wdata),
    .ok(valueOk)
  );

  // a miss refuses reads and writes alike; a bad value refuses the write
  assign refused = req.valid && (!dec.hit ||
    (req.write && !valueOk));
  assign writeOk = req.valid && req.write && dec.hit && valueOk;

  ////////////////////////////////////////////////////////////////////////
  // storage: one flop word per parameter

  for (genvar g = 0; g < `NUM_PARAMS; g++)
  begin : g_slot
    localparam logic [15:0] RST = resetValue(g);
    // only an accepted write to this slot changes it
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
      begin
        bank[g] <= RST;
      end
      else if (writeOk && (dec.idx == param_idx_t'(g)))
      begin
        bank[g] <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer: one cycle after the request, every request answered

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp.ack <= req.valid;
      rsp.err <= refused;
      // read data only on a good read, so stale words never leak out
      if (req.valid && !req.write && dec.hit)
      begin
        rsp.rdata <= bank[dec.idx];
      end
      else
      begin
        rsp.rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded settings, registered from the stored words
  // costs one cycle of lag after a write, but keeps the outputs on flops

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkCfg.rate <= rate_t'(3'(`RST_LINE_RATE));
      linkCfg.node <= 6'(`RST_NODE);
      linkCfg.eightBits <= 1'b1;
      linkCfg.parity <= PAR_NONE;
      linkCfg.twoStop <= 1'b0;
      linkCfg.rtuMode <= 1'b0;
      linkCfg.errAction <= ERR_TRIP;
      linkCfg.alarmWidth <= ALARM_OFF;
    end
    else
    begin
      linkCfg.rate <= rate_t'(bank[IX_LINE_RATE][2:0]);
      linkCfg.node <= bank[IX_NODE][5:0];
      // only 7 and 8 are stored, so a compare with eight is enough
      linkCfg.eightBits <= (bank[IX_CHAR_LEN] == `CHAR_MAX);
      linkCfg.parity <= parity_t'(bank[IX_PARITY][1:0]);
      linkCfg.twoStop <= (bank[IX_STOP_BITS] == `STOP_MAX);
      linkCfg.rtuMode <= bank[IX_PROTOCOL][0];
      linkCfg.errAction <= err_action_t'(bank[IX_ERR_ACTION][2:0]);
      linkCfg.alarmWidth <= alarm_w_t'(bank[IX_ALARM_W][1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // the first threshold pair never holds more than the top frequency
  a_freq_pair_range: assert property (
    bank[IX_ACCEL_HI] == 16'h0000 && bank[IX_ACCEL_LO] <= `LIM_FREQ &&
    bank[IX_DECEL_HI] == 16'h0000 && bank[IX_DECEL_LO] <= `LIM_FREQ)
    else $error("first threshold pair out of range");

  a_decel_word_write: assert property (
    req.valid && req.write && req.addr == `ADDR_DECEL_LO &&
    req.wdata <= `LIM_FREQ |=> bank[IX_DECEL_LO] == $past(req.wdata))
    else $error("decel low word write lost");

  a_freq2_pair_range: assert property (
    bank[IX_ACCEL2_HI] == 16'h0000 && bank[IX_ACCEL2_LO] <= `LIM_FREQ &&
    bank[IX_DECEL2_HI] == 16'h0000 && bank[IX_DECEL2_LO] <= `LIM_FREQ)
    else $error("second threshold pair out of range");

  a_pid_levels_range: assert property (
    bank[IX_PID_DEV] <= `LIM_TENTH_PCT &&
    bank[IX_PID_FB_MAX] <= `LIM_TENTH_PCT &&
    bank[IX_PID_FB_MIN] <= `LIM_TENTH_PCT)
    else $error("pid level out of range");

  a_torque_levels_range: assert property (
    bank[IX_OTQ_FD] <= `LIM_TORQUE && bank[IX_OTQ_RR] <= `LIM_TORQUE &&
    bank[IX_OTQ_RD] <= `LIM_TORQUE && bank[IX_OTQ_FR] <= `LIM_TORQUE)
    else $error("over-torque level out of range");

  a_warning_levels_range: assert property (
    bank[IX_THERMAL] <= `LIM_THERMAL && bank[IX_HEATSINK] <= `LIM_HEATSINK &&
    bank[IX_ZERO_SPD] <= `LIM_ZERO_SPD)
    else $error("warning level out of range");

  a_link_codes_legal: assert property (
    bank[IX_LINE_RATE] >= `RATE_MIN && bank[IX_LINE_RATE] <= `RATE_MAX &&
    bank[IX_CHAR_LEN] >= `CHAR_MIN && bank[IX_CHAR_LEN] <= `CHAR_MAX &&
    bank[IX_PARITY] <= `LIM_PARITY && bank[IX_STOP_BITS] >= `STOP_MIN &&
    bank[IX_STOP_BITS] <= `STOP_MAX && bank[IX_PROTOCOL] <= `LIM_PROTOCOL)
    else $error("link setting code illegal");

  a_action_follows_word: assert property (
    ##1 linkCfg.errAction == err_action_t'($past(bank[IX_ERR_ACTION][2:0])) &&
    linkCfg.alarmWidth == alarm_w_t'($past(bank[IX_ALARM_W][1:0])))
    else $error("error action or alarm width not tracking");

  a_reserved_refused: assert property (
    req.valid && !dec.hit |=> rsp.ack && rsp.err &&
    rsp.rdata == 16'h0000 && $stable(bank))
    else $error("reserved access not refused");

  a_bad_value_kept: assert property (
    req.valid && req.write && dec.hit && !valueOk
    |=> rsp.err && $stable(bank))
    else $error("out-of-range write changed the bank");

  a_read_returns_word: assert property (
    req.valid && !req.write && dec.hit
    |=> rsp.ack && !rsp.err && rsp.rdata == $past(bank[dec.idx]))
    else $error("read returned the wrong word");

  a_idle_no_answer: assert property (
    !req.valid |=> !rsp.ack && !rsp.err)
    else $error("answer without a request");

  // an in-range low word lands on the next edge
  a_accel_word_write: assert property (
    req.valid && req.write && req.addr == `ADDR_ACCEL_LO &&
    req.wdata <= `LIM_FREQ |=> bank[IX_ACCEL_LO] == $past(req.wdata))
    else $error("accel low word write lost");

  // same for the second threshold pair
  a_accel2_word_write: assert property (
    req.valid && req.write && req.addr == `ADDR_ACCEL2_LO &&
    req.wdata <= `LIM_FREQ |=> bank[IX_ACCEL2_LO] == $past(req.wdata))
    else $error("second accel low word write lost");

  // feedback minimum takes any value up to the limit
  a_pid_min_write: assert property (
    req.valid && req.write && req.addr == `ADDR_PID_FB_MIN &&
    req.wdata <= `LIM_TENTH_PCT |=> bank[IX_PID_FB_MIN] == $past(req.wdata))
    else $error("pid feedback min write lost");

  // alarm selector holds off, 3 or 4 bits only
  a_alarm_code_legal: assert property (
    bank[IX_ALARM_W] <= `LIM_ALARM_W)
    else $error("alarm code width illegal");

  // zero-speed level stays at or below its limit
  a_zero_speed_range: assert property (
    bank[IX_ZERO_SPD] <= `LIM_ZERO_SPD)
    else $error("zero-speed level out of range");

  // heat-sink level stays at or below its limit
  a_heatsink_range: assert property (
    bank[IX_HEATSINK] <= `LIM_HEATSINK)
    else $error("heat-sink level out of range");

  // decoded rate follows the stored code one cycle later
  a_rate_follows: assert property (
    ##1 linkCfg.rate == rate_t'($past(bank[IX_LINE_RATE][2:0])))
    else $error("line rate not tracking");

  // eight-bit flag set only by code eight
  a_length_follows: assert property (
    ##1 linkCfg.eightBits == ($past(bank[IX_CHAR_LEN]) == `CHAR_MAX))
    else $error("character length not tracking");

  // parity code passes through unchanged
  a_parity_follows: assert property (
    ##1 linkCfg.parity == parity_t'($past(bank[IX_PARITY][1:0])))
    else $error("parity not tracking");

  // two-stop flag set only by code two
  a_stop_follows: assert property (
    ##1 linkCfg.twoStop == ($past(bank[IX_STOP_BITS]) == `STOP_MAX))
    else $error("stop bits not tracking");

  // only the five documented reactions are ever held
  a_action_code_legal: assert property (
    bank[IX_ERR_ACTION] <= `LIM_ERR_ACTION)
    else $error("error action code illegal");

  // protocol flag follows the stored word
  a_protocol_follows: assert property (
    ##1 linkCfg.rtuMode == $past(bank[IX_PROTOCOL][0]))
    else $error("protocol select not tracking");

  // an accepted write is answered without error
  a_good_write_acked: assert property (
    writeOk |=> rsp.ack && !rsp.err)
    else $error("good write not acknowledged");

  // nothing but an accepted write moves the bank
  a_bank_holds_idle: assert property (
    !writeOk |=> $stable(bank))
    else $error("bank changed without a write");

  // main scenarios
  c_good_write: cover property (writeOk ##1 rsp.ack && !rsp.err);
  c_reserved_hit: cover property (req.valid && !dec.hit ##1 rsp.err);
  c_range_refusal: cover property (req.valid && req.write && dec.hit &&
    !valueOk);
  c_rtu_selected: cover property (linkCfg.rtuMode);
  c_reserved_read: cover property (req.valid && !req.write && !dec.hit);

endmodule : drive_param_bank

// file: core/drive_param_params.svh
// constants for the drive parameter bank: register numbers, limits, resets
// assumes it is included by bare name from the package and the design files
`ifndef DRIVE_PARAM_PARAMS_SVH
`define DRIVE_PARAM_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// register numbers as seen on the serial link
`define ADDR_ACCEL_HI 16'h142a
`define ADDR_ACCEL_LO 16'h142b
`define ADDR_DECEL_HI 16'h142c
`define ADDR_DECEL_LO 16'h142d
`define ADDR_PID_DEV 16'h142e
`define ADDR_ACCEL2_HI 16'h142f
`define ADDR_ACCEL2_LO 16'h1430
`define ADDR_DECEL2_HI 16'h1431
`define ADDR_DECEL2_LO 16'h1432
`define ADDR_PID_FB_MAX 16'h1438
`define ADDR_PID_FB_MIN 16'h1439
`define ADDR_OTQ_FD 16'h143b
`define ADDR_OTQ_RR 16'h143c
`define ADDR_OTQ_RD 16'h143d
`define ADDR_OTQ_FR 16'h143e
`define ADDR_THERMAL 16'h1441
`define ADDR_ALARM_W 16'h1442
`define ADDR_ZERO_SPD 16'h1443
`define ADDR_HEATSINK 16'h1444
`define ADDR_LINE_RATE 16'h144b
`define ADDR_NODE 16'h144c
`define ADDR_CHAR_LEN 16'h144d
`define ADDR_PARITY 16'h144e
`define ADDR_STOP_BITS 16'h144f
`define ADDR_ERR_ACTION 16'h1450
`define ADDR_PROTOCOL 16'h1453

// number of stored parameters
`define NUM_PARAMS 26

////////////////////////////////////////////////////////////////////////////
// accepted value limits (inclusive)
`define LIM_FREQ 16'h9c40
`define LIM_TENTH_PCT 16'h03e8
`define LIM_TORQUE 16'h0096
`define LIM_THERMAL 16'h0064
`define LIM_ZERO_SPD 16'h2710
`define LIM_HEATSINK 16'h00c8
`define LIM_ALARM_W 16'h0002
`define RATE_MIN 16'h0002
`define RATE_MAX 16'h0006
`define NODE_MIN 16'h0001
`define NODE_MAX 16'h0020
`define CHAR_MIN 16'h0007
`define CHAR_MAX 16'h0008
`define LIM_PARITY 16'h0002
`define STOP_MIN 16'h0001
`define STOP_MAX 16'h0002
`define LIM_ERR_ACTION 16'h0004
`define LIM_PROTOCOL 16'h0001

////////////////////////////////////////////////////////////////////////////
// reset values; parameters not listed reset to zero
`define RST_ZERO 16'h0000
`define RST_LINE_RATE 16'h0005
`define RST_NODE 16'h0001
`define RST_CHAR_LEN 16'h0008
`define RST_STOP_BITS 16'h0001

`endif

// file: core/drive_param_pkg.sv
// types shared by the drive parameter bank and its range checker
// assumes the params header sits beside it on the include path
package drive_param_pkg;

  // storage slot of each parameter
  typedef enum logic [4:0] {
    IX_ACCEL_HI, IX_ACCEL_LO, IX_DECEL_HI, IX_DECEL_LO, IX_PID_DEV,
    IX_ACCEL2_HI, IX_ACCEL2_LO, IX_DECEL2_HI, IX_DECEL2_LO,
    IX_PID_FB_MAX, IX_PID_FB_MIN, IX_OTQ_FD, IX_OTQ_RR, IX_OTQ_RD,
    IX_OTQ_FR, IX_THERMAL, IX_ALARM_W, IX_ZERO_SPD, IX_HEATSINK,
    IX_LINE_RATE, IX_NODE, IX_CHAR_LEN, IX_PARITY, IX_STOP_BITS,
    IX_ERR_ACTION, IX_PROTOCOL
  } param_idx_t;

  // result of decoding a register number
  typedef struct packed {
    logic hit;
    param_idx_t idx;
  } addr_hit_t;

  // one access from the link decoder
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } param_req_t;

  // answer to one access
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } param_rsp_t;

  // line rate encodings
  typedef enum logic [2:0] {
    RATE_LOOPBACK = 3'h2, RATE_2400, RATE_4800, RATE_9600, RATE_19200
  } rate_t;

  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;

  typedef enum logic [1:0] {ALARM_OFF, ALARM_3BIT, ALARM_4BIT} alarm_w_t;

  // action taken on a link error
  typedef enum logic [2:0] {
    ERR_TRIP, ERR_DECEL_TRIP, ERR_IGNORE, ERR_COAST, ERR_DECEL_STOP
  } err_action_t;

  // decoded link and alarm settings for the rest of the drive
  typedef struct packed {
    rate_t rate;
    logic [5:0] node;
    logic eightBits;
    parity_t parity;
    logic twoStop;
    logic rtuMode;
    err_action_t errAction;
    alarm_w_t alarmWidth;
  } link_cfg_t;

endpackage : drive_param_pkg

// file: core/param_range_check.sv
// range checker: says whether a value may be stored into a parameter slot
// assumes a purely combinational use from the bank on the same clock
`timescale 1ns/100ps
`include "drive_param_params.svh"

module param_range_check
  import drive_param_pkg::*;
(
  input wire param_idx_t idx,
  input wire logic [15:0] value,
  output logic ok
);

  // one limit check per slot; high words of 32-bit thresholds must be zero
  // because the whole threshold fits below 2^16
  always_comb
  begin
    case (idx)
      IX_ACCEL_HI, IX_DECEL_HI, IX_ACCEL2_HI, IX_DECEL2_HI:
        ok = (value == 16'h0000);
      IX_ACCEL_LO, IX_DECEL_LO, IX_ACCEL2_LO, IX_DECEL2_LO:
        ok = (value <= `LIM_FREQ);
      IX_PID_DEV, IX_PID_FB_MAX, IX_PID_FB_MIN:
        ok = (value <= `LIM_TENTH_PCT);
      IX_OTQ_FD, IX_OTQ_RR, IX_OTQ_RD, IX_OTQ_FR:
        ok = (value <= `LIM_TORQUE);
      IX_THERMAL: ok = (value <= `LIM_THERMAL);
      IX_ALARM_W: ok = (value <= `LIM_ALARM_W);
      IX_ZERO_SPD: ok = (value <= `LIM_ZERO_SPD);
      IX_HEATSINK: ok = (value <= `LIM_HEATSINK);
      IX_LINE_RATE:
        ok = (value >= `RATE_MIN) && (value <= `RATE_MAX);
      IX_NODE: ok = (value >= `NODE_MIN) && (value <= `NODE_MAX);
      IX_CHAR_LEN:
        ok = (value >= `CHAR_MIN) && (value <= `CHAR_MAX);
      IX_PARITY: ok = (value <= `LIM_PARITY);
      IX_STOP_BITS:
        ok = (value >= `STOP_MIN) && (value <= `STOP_MAX);
      IX_ERR_ACTION: ok = (value <= `LIM_ERR_ACTION);
      IX_PROTOCOL: ok = (value <= `LIM_PROTOCOL);
      default: ok = 1'b0;
    endcase
  end

endmodule : param_range_check

// file: test/link_host_model.sv
// host model: issues register accesses on the bank's access port
// assumes clk_sys from the bench; requests change on the falling edge
`timescale 1ns/100ps

module link_host_model
  import drive_param_pkg::*;
(
  input wire logic clk_sys,
  output param_req_t req,
  input wire param_rsp_t rsp
);
  // idle at time zero so the bank never sees an unknown request
  initial req = '{1'b0, 1'b0, 16'h0000, 16'h0000};

  ////////////////////////////////////////////////////////////
  // one access: valid for a single cycle, answer awaited under a bound;
  // released address and data carry the inverse of the last value, not stale data
  task automatic access(input logic w, input logic [15:0] a,
    input logic [15:0] d, output logic [1:0] st,
    output logic [15:0] q, output int lat);
    @(negedge clk_sys);
    req <= '{1'b1, w, a, d};
    @(negedge clk_sys);
    req <= '{1'b0, w, ~a, ~d};
    lat = 0;
    // ack should already stand; a few more cycles expose a late one
    while (rsp.ack !== 1'b1 && lat < 8)
    begin
      @(negedge clk_sys);
      lat++;
    end
    st = {rsp.ack, rsp.err};
    q = rsp.rdata;
  endtask : access

  // two writes on consecutive cycles, no idle cycle between them
  task automatic pair(input logic [15:0] a0, input logic [15:0] d0,
    input logic [15:0] a1, input logic [15:0] d1, output logic [3:0] st);
    @(negedge clk_sys);
    req <= '{1'b1, 1'b1, a0, d0};
    @(negedge clk_sys);
    req <= '{1'b1, 1'b1, a1, d1};
    st[3:2] = {rsp.ack, rsp.err};
    @(negedge clk_sys);
    req <= '{1'b0, 1'b1, ~a1, ~d1};
    st[1:0] = {rsp.ack, rsp.err};
  endtask : pair
endmodule : link_host_model

// file: test/drive_parameter_register_bank_test.sv
// bench for the drive parameter bank: reset, ranges, codes, refusals
// assumes the host model drives the access port; one clock, one reset
`timescale 1ns/100ps
`include "drive_param_params.svh"

module drive_parameter_register_bank_test
  import drive_param_pkg::*;
;
  logic clk_sys; // 250 MHz system clock
  logic arst_n; // asynchronous reset, low active
  param_req_t req;
  param_rsp_t rsp;
  logic [`NUM_PARAMS-1:0][15:0] bank;
  link_cfg_t linkCfg;
  int errorCnt;
  int samplesChecked;
  // register numbers, in slot order
  logic [15:0] regAddr [`NUM_PARAMS] = '{`ADDR_ACCEL_HI, `ADDR_ACCEL_LO,
    `ADDR_DECEL_HI, `ADDR_DECEL_LO, `ADDR_PID_DEV, `ADDR_ACCEL2_HI,
    `ADDR_ACCEL2_LO, `ADDR_DECEL2_HI, `ADDR_DECEL2_LO, `ADDR_PID_FB_MAX,
    `ADDR_PID_FB_MIN, `ADDR_OTQ_FD, `ADDR_OTQ_RR, `ADDR_OTQ_RD,
    `ADDR_OTQ_FR, `ADDR_THERMAL, `ADDR_ALARM_W, `ADDR_ZERO_SPD,
    `ADDR_HEATSINK, `ADDR_LINE_RATE, `ADDR_NODE, `ADDR_CHAR_LEN,
    `ADDR_PARITY, `ADDR_STOP_BITS, `ADDR_ERR_ACTION, `ADDR_PROTOCOL};
  // largest accepted value of each slot; high words take zero only
  logic [15:0] regMax [`NUM_PARAMS] = '{16'h0000, `LIM_FREQ,
    16'h0000, `LIM_FREQ, `LIM_TENTH_PCT, 16'h0000, `LIM_FREQ,
    16'h0000, `LIM_FREQ, `LIM_TENTH_PCT, `LIM_TENTH_PCT,
    `LIM_TORQUE, `LIM_TORQUE, `LIM_TORQUE, `LIM_TORQUE,
    `LIM_THERMAL, `LIM_ALARM_W, `LIM_ZERO_SPD, `LIM_HEATSINK,
    `RATE_MAX, `NODE_MAX, `CHAR_MAX, `LIM_PARITY, `STOP_MAX,
    `LIM_ERR_ACTION, `LIM_PROTOCOL};
  logic [15:0] regMin [`NUM_PARAMS]; // smallest accepted value

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  drive_param_bank i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .req(req),
    .rsp(rsp), .bank(bank), .linkCfg(linkCfg));

  link_host_model i_host (.clk_sys(clk_sys), .req(req), .rsp(rsp));

  ////////////////////////////////////////////////////////////
  // shared compare, read and write helpers
  task automatic check(input string what, input logic [15:0] got,
    input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // write, then one more cycle so the decoded settings catch up
  task automatic put(input logic [15:0] a, input logic [15:0] d,
    input logic [1:0] st);
    logic [1:0] s;
    logic [15:0] q;
    int lat;
    i_host.access(1'b1, a, d, s, q, lat);
    check("write status", 16'(s), 16'(st));
    check("write delay", 16'(lat), 16'h0000);
    @(negedge clk_sys);
  endtask : put

  // read; answer must be gone again one cycle later
  task automatic get(input logic [15:0] a, input logic [15:0] d,
    input logic [1:0] st);
    logic [1:0] s;
    logic [15:0] q;
    int lat;
    i_host.access(1'b0, a, 16'h0000, s, q, lat);
    check("read status", 16'(s), 16'(st));
    check("read data", q, d);
    @(negedge clk_sys);
    check("ack dropped", 16'(rsp.ack), 16'h0000);
    check("data dropped", rsp.rdata, 16'h0000);
  endtask : get

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic testReset();
    logic [15:0] e;
    for (int i = 0; i < `NUM_PARAMS; i++)
    begin
      e = `RST_ZERO;
      if (i == IX_LINE_RATE) e = `RST_LINE_RATE;
      if (i == IX_NODE) e = `RST_NODE;
      if (i == IX_CHAR_LEN) e = `RST_CHAR_LEN;
      if (i == IX_STOP_BITS) e = `RST_STOP_BITS;
      check("reset word", bank[i], e);
    end
    check("reset rate", 16'(linkCfg.rate), `RST_LINE_RATE);
    check("reset node", 16'(linkCfg.node), `RST_NODE);
    check("reset length", 16'(linkCfg.eightBits), 16'h0001);
    check("reset rest", 16'({linkCfg.parity, linkCfg.twoStop,
      linkCfg.rtuMode, linkCfg.errAction, linkCfg.alarmWidth}), 16'h0000);
    get(`ADDR_LINE_RATE, `RST_LINE_RATE, 2'b10);
    $display("testReset done");
  endtask : testReset

  // each slot: top value kept, one past it refused; bottom value stored, one below it refused where the minimum is nonzero
  task automatic testRanges();
    for (int i = 0; i < `NUM_PARAMS; i++)
    begin
      put(regAddr[i], regMax[i], 2'b10);
      get(regAddr[i], regMax[i], 2'b10);
      put(regAddr[i], regMax[i] + 16'h0001, 2'b11);
      check("kept above", bank[i], regMax[i]);
      if (regMin[i] != 16'h0000)
      begin
        put(regAddr[i], regMin[i] - 16'h0001, 2'b11);
        check("kept below", bank[i], regMax[i]);
      end
      put(regAddr[i], regMin[i], 2'b10);
      check("low stored", bank[i], regMin[i]);
    end
    $display("testRanges done");
  endtask : testRanges

  // every selector code reaches the decoded settings
  task automatic testCodes();
    logic [15:0] v;
    for (v = 16'h0002; v <= 16'h0006; v++)
    begin
      put(`ADDR_LINE_RATE, v, 2'b10);
      check("rate code", 16'(linkCfg.rate), v);
    end
    for (v = 16'h0000; v <= 16'h0002; v++)
    begin
      put(`ADDR_PARITY, v, 2'b10);
      check("parity code", 16'(linkCfg.parity), v);
      put(`ADDR_ALARM_W, v, 2'b10);
      check("alarm code", 16'(linkCfg.alarmWidth), v);
    end
    for (v = 16'h0000; v <= 16'h0004; v++)
    begin
      put(`ADDR_ERR_ACTION, v, 2'b10);
      check("error action", 16'(linkCfg.errAction), v);
    end
    for (v = 16'h0000; v <= 16'h0001; v++)
    begin
      put(`ADDR_CHAR_LEN, v + 16'h0007, 2'b10);
      check("eight bits", 16'(linkCfg.eightBits), v);
      put(`ADDR_STOP_BITS, v + 16'h0001, 2'b10);
      check("two stop", 16'(linkCfg.twoStop), v);
      put(`ADDR_PROTOCOL, v, 2'b10);
      check("rtu mode", 16'(linkCfg.rtuMode), v);
    end
    put(`ADDR_NODE, `NODE_MAX, 2'b10);
    check("node", 16'(linkCfg.node), `NODE_MAX);
    $display("testCodes done");
  endtask : testCodes

  // reserved and unmapped numbers: refused both ways, nothing stored
  task automatic testReserved();
    logic [`NUM_PARAMS-1:0][15:0] snap;
    logic [15:0] bad [10] = '{16'h1433, 16'h1437, 16'h143a, 16'h143f,
      16'h1440, 16'h1445, 16'h144a, 16'h1429, 16'h1451, 16'h1454};
    snap = bank;
    foreach (bad[k])
    begin
      put(bad[k], 16'h0001, 2'b11);
      get(bad[k], 16'h0000, 2'b11);
      check("bank kept", 16'(bank !== snap), 16'h0000);
    end
    $display("testReserved done");
  endtask : testReserved

  // refused write followed at once by a good one
  task automatic testBackToBack();
    logic [3:0] st;
    logic [15:0] old;
    old = bank[IX_OTQ_FD];
    i_host.pair(`ADDR_OTQ_FD, `LIM_TORQUE + 16'h0001, `ADDR_LINE_RATE,
      16'h0003, st);
    check("pair status", 16'(st), 16'h000e);
    @(negedge clk_sys);
    check("torque kept", bank[IX_OTQ_FD], old);
    check("rate taken", 16'(linkCfg.rate), 16'h0003);
    $display("testBackToBack done");
  endtask : testBackToBack

  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrapUp

  // the tests need well under 5000 cycles; 20000 marks a hang
  initial
  begin
    #80000;
    errorCnt++;
    wrapUp();
  end

  initial
  begin
    errorCnt = 0;
    samplesChecked = 0;
    regMin = '{default: 16'h0000};
    regMin[IX_LINE_RATE] = `RATE_MIN;
    regMin[IX_NODE] = `NODE_MIN;
    regMin[IX_CHAR_LEN] = `CHAR_MIN;
    regMin[IX_STOP_BITS] = `STOP_MIN;
    arst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    testReset();
    testRanges();
    testCodes();
    testReserved();
    testBackToBack();
    wrapUp();
  end
endmodule : drive_parameter_register_bank_test
